// ==== logic/sat_pkg.sv ====
// constants for the split auto-reload timer control block
package sat_pkg;
   // =====================================================
   // register addresses on the special-function-register bus
   localparam logic [7:0] ADDR_CTRL = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LO = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HI = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LO = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HI = 8'h95;

   // =====================================================
   // timer_mode_and_flags_control field positions
   localparam int BIT_UPPER_WRAP = 7;
   localparam int BIT_LOWER_WRAP = 6;
   localparam int BIT_LOWER_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_DUAL_MODE = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_ALT_CLK_HI = 1;
   localparam int BIT_ALT_CLK_LO = 0;

   // =====================================================
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // =====================================================
   // alternate clock select encodings
   localparam logic [1:0] ALT_SYSTEM_CLOCK_DIV12 = 2'h0;
   localparam logic [1:0] ALT_EXT_DIV8 = 2'h1;
   localparam logic [1:0] ALT_RESERVED = 2'h2;
   localparam logic [1:0] ALT_SLOW_DIV8 = 2'h3;

   // =====================================================
   // counting constants
   localparam int SYSTEM_CLOCK_DIVIDE = 12;
   localparam logic [3:0] PRESCALE_LAST = 4'(SYSTEM_CLOCK_DIVIDE - 1);
   localparam logic [3:0] PRESCALE_RESET = 4'h0;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   localparam int PIN_COUNT = 3;
   localparam int PIN_EXT_DIV8 = 0;
   localparam int PIN_SLOW_DIV8 = 1;
   localparam int PIN_SLOW_RAW = 2;
endpackage

// ==== logic/sat_timer.sv ====
// split auto-reload timer: control register, counters, reload, capture, interrupt request
`timescale 1ns/1ns
module sat_timer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic upper_byte_system_clock_select,
   input wire logic lower_byte_system_clock_select,
   input wire logic ext_osc_div8,
   input wire logic slow_osc_div8,
   input wire logic slow_internal_oscillator,
   output logic timer_irq_req
);
   // =====================================================
   // state
   logic [7:0] ctrl;
   logic [7:0] reload_lower_byte;
   logic [7:0] reload_upper_byte;
   logic [7:0] count_lower_byte;
   logic [7:0] count_upper_byte;
   logic [3:0] prescale;
   logic [sat_pkg::PIN_COUNT-1:0] pin_s1;
   logic [sat_pkg::PIN_COUNT-1:0] pin_s2;
   logic [sat_pkg::PIN_COUNT-1:0] pin_d;
   logic [7:0] next_ctrl;
   logic [7:0] next_reload_lower_byte;
   logic [7:0] next_reload_upper_byte;
   logic [7:0] next_count_lower_byte;
   logic [7:0] next_count_upper_byte;
   logic [3:0] next_prescale;
   logic [7:0] next_sfr_rdata;
   logic next_timer_irq_req;

   // =====================================================
   // field views
   logic upper_byte_wrap_flag;
   logic lower_byte_wrap_flag;
   logic lower_byte_irq_enable;
   logic slow_osc_capture_enable;
   logic dual_8bit_mode_select;
   logic count_run_control;
   logic [1:0] alternate_clock_select;

   assign upper_byte_wrap_flag = ctrl[sat_pkg::BIT_UPPER_WRAP];
   assign lower_byte_wrap_flag = ctrl[sat_pkg::BIT_LOWER_WRAP];
   assign lower_byte_irq_enable = ctrl[sat_pkg::BIT_LOWER_IRQ_EN];
   assign slow_osc_capture_enable = ctrl[sat_pkg::BIT_CAPTURE_EN];
   assign dual_8bit_mode_select = ctrl[sat_pkg::BIT_DUAL_MODE];
   assign count_run_control = ctrl[sat_pkg::BIT_RUN];
   assign alternate_clock_select = ctrl[sat_pkg::BIT_ALT_CLK_HI:sat_pkg::BIT_ALT_CLK_LO];

   // =====================================================
   // pin synchronisers and edge detection
   logic [sat_pkg::PIN_COUNT-1:0] pin_raw;
   logic [sat_pkg::PIN_COUNT-1:0] pin_rise;
   logic [sat_pkg::PIN_COUNT-1:0] pin_fall;

   assign pin_raw[sat_pkg::PIN_EXT_DIV8] = ext_osc_div8;
   assign pin_raw[sat_pkg::PIN_SLOW_DIV8] = slow_osc_div8;
   assign pin_raw[sat_pkg::PIN_SLOW_RAW] = slow_internal_oscillator;

   genvar gi;
   generate
      for (gi = 0; gi < sat_pkg::PIN_COUNT; gi++) begin : g_pin
         // edges come from the second stage only, the first may be metastable
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
               pin_d[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_d[gi] <= pin_s2[gi];
            end
         end
         assign pin_rise[gi] = pin_s2[gi] & ~pin_d[gi];
         assign pin_fall[gi] = ~pin_s2[gi] & pin_d[gi];
      end
   endgenerate

   // =====================================================
   // count enables
   logic tick_div12;
   logic alt_tick;
   logic tick_lower;
   logic tick_upper;
   logic inc_lower;
   logic inc_upper;
   logic wrap_lower;
   logic wrap_upper;
   logic capture;
   logic wr_ctrl;
   logic [15:0] count_word;

   assign tick_div12 = (prescale == sat_pkg::PRESCALE_LAST);
   assign count_word = {count_upper_byte, count_lower_byte};
   assign wr_ctrl = sfr_wr && (sfr_addr == sat_pkg::ADDR_CTRL);

   always_comb begin
      unique case (alternate_clock_select)
         sat_pkg::ALT_SYSTEM_CLOCK_DIV12: alt_tick = tick_div12;
         sat_pkg::ALT_EXT_DIV8: alt_tick = pin_rise[sat_pkg::PIN_EXT_DIV8];
         sat_pkg::ALT_SLOW_DIV8: alt_tick = pin_rise[sat_pkg::PIN_SLOW_DIV8];
         sat_pkg::ALT_RESERVED: alt_tick = 1'b0;
      endcase
      // the same alternate source feeds both bytes, each may take system_clock instead
      tick_lower = lower_byte_system_clock_select | alt_tick;
      tick_upper = upper_byte_system_clock_select | alt_tick;
      if (dual_8bit_mode_select) begin
         inc_lower = tick_lower;
         inc_upper = tick_upper & count_run_control;
      end else begin
         inc_lower = tick_lower & count_run_control;
         inc_upper = 1'b0;
      end
      wrap_lower = inc_lower && (count_lower_byte == sat_pkg::BYTE_MAX);
      if (dual_8bit_mode_select) begin
         wrap_upper = inc_upper && (count_upper_byte == sat_pkg::BYTE_MAX);
      end else begin
         wrap_upper = inc_lower && (count_word == sat_pkg::WORD_MAX);
      end
      capture = slow_osc_capture_enable & pin_fall[sat_pkg::PIN_SLOW_RAW];
   end

   // =====================================================
   // register write decode
   // writes to unmapped addresses decode to nothing and are dropped
   logic wr_reload_lo;
   logic wr_reload_hi;
   logic wr_count_lo;
   logic wr_count_hi;

   assign wr_reload_lo = sfr_wr && (sfr_addr == sat_pkg::ADDR_RELOAD_LO);
   assign wr_reload_hi = sfr_wr && (sfr_addr == sat_pkg::ADDR_RELOAD_HI);
   assign wr_count_lo = sfr_wr && (sfr_addr == sat_pkg::ADDR_COUNT_LO);
   assign wr_count_hi = sfr_wr && (sfr_addr == sat_pkg::ADDR_COUNT_HI);

   // =====================================================
   // prescaler: free running, so a source change never restarts the div12 phase
   always_comb begin
      next_prescale = tick_div12 ? sat_pkg::PRESCALE_RESET : 4'(prescale + 4'h1);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prescale <= sat_pkg::PRESCALE_RESET;
      end else begin
         prescale <= next_prescale;
      end
   end

   // =====================================================
   // counters: a software write to a count byte wins over counting
   // the word is not latched, so a carry may land between reading the two bytes
   always_comb begin
      next_count_lower_byte = count_lower_byte;
      next_count_upper_byte = count_upper_byte;
      if (dual_8bit_mode_select) begin
         if (inc_lower) begin
            next_count_lower_byte = wrap_lower ? reload_lower_byte
                                               : 8'(count_lower_byte + 8'h01);
         end
         if (inc_upper) begin
            next_count_upper_byte = wrap_upper ? reload_upper_byte
                                               : 8'(count_upper_byte + 8'h01);
         end
      end else if (inc_lower) begin
         if (wrap_upper) begin
            next_count_lower_byte = reload_lower_byte;
            next_count_upper_byte = reload_upper_byte;
         end else begin
            {next_count_upper_byte, next_count_lower_byte} = 16'(count_word + 16'h0001);
         end
      end
      if (wr_count_lo) begin
         next_count_lower_byte = sfr_wdata;
      end
      if (wr_count_hi) begin
         next_count_upper_byte = sfr_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count_lower_byte <= sat_pkg::BYTE_RESET;
         count_upper_byte <= sat_pkg::BYTE_RESET;
      end else begin
         count_lower_byte <= next_count_lower_byte;
         count_upper_byte <= next_count_upper_byte;
      end
   end

   // =====================================================
   // reload pair: a capture edge wins over a software write so no sample is lost
   always_comb begin
      next_reload_lower_byte = reload_lower_byte;
      next_reload_upper_byte = reload_upper_byte;
      if (wr_reload_lo) begin
         next_reload_lower_byte = sfr_wdata;
      end
      if (wr_reload_hi) begin
         next_reload_upper_byte = sfr_wdata;
      end
      if (capture) begin
         next_reload_lower_byte = count_lower_byte;
         next_reload_upper_byte = count_upper_byte;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reload_lower_byte <= sat_pkg::BYTE_RESET;
         reload_upper_byte <= sat_pkg::BYTE_RESET;
      end else begin
         reload_lower_byte <= next_reload_lower_byte;
         reload_upper_byte <= next_reload_upper_byte;
      end
   end

   // =====================================================
   // control: flags only ever cleared by a software write of zero
   always_comb begin
      next_ctrl = wr_ctrl ? sfr_wdata : ctrl;
      next_ctrl[sat_pkg::BIT_UPPER_WRAP] = next_ctrl[sat_pkg::BIT_UPPER_WRAP]
                                           | wrap_upper | capture;
      next_ctrl[sat_pkg::BIT_LOWER_WRAP] = next_ctrl[sat_pkg::BIT_LOWER_WRAP]
                                           | wrap_lower;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl <= sat_pkg::CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // =====================================================
   // interrupt request: follows the stored flags one cycle later
   // the enable is a level, so dropping it withdraws the request next cycle
   always_comb begin
      next_timer_irq_req = timer_irq_enable
                           & (upper_byte_wrap_flag
                              | (lower_byte_irq_enable & lower_byte_wrap_flag));
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer_irq_req <= 1'h0;
      end else begin
         timer_irq_req <= next_timer_irq_req;
      end
   end

   // =====================================================
   // read data: shows the value before any write in the same cycle
   always_comb begin
      next_sfr_rdata = sfr_rdata;
      if (sfr_rd) begin
         unique case (sfr_addr)
            sat_pkg::ADDR_CTRL: next_sfr_rdata = ctrl;
            sat_pkg::ADDR_RELOAD_LO: next_sfr_rdata = reload_lower_byte;
            sat_pkg::ADDR_RELOAD_HI: next_sfr_rdata = reload_upper_byte;
            sat_pkg::ADDR_COUNT_LO: next_sfr_rdata = count_lower_byte;
            sat_pkg::ADDR_COUNT_HI: next_sfr_rdata = count_upper_byte;
            default: next_sfr_rdata = sat_pkg::READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sfr_rdata <= sat_pkg::BYTE_RESET;
      end else begin
         sfr_rdata <= next_sfr_rdata;
      end
   end
endmodule

// ==== verif/sat_timer_props.sv ====
// concurrent checks on the ports of the split auto-reload timer
`timescale 1ns/1ns
module sat_timer_props (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic upper_byte_system_clock_select,
   input wire logic lower_byte_system_clock_select,
   input wire logic ext_osc_div8,
   input wire logic slow_osc_div8,
   input wire logic slow_internal_oscillator,
   input wire logic timer_irq_req
);
   // =========================================
   // flags seen set by reads; a read racing a control write is not trusted
   logic rd_q;
   logic cw_q;
   logic [1:0] held;
   logic [7:0] last_wd;
   wire c_wr = sfr_wr && sfr_addr == sat_pkg::ADDR_CTRL;
   wire c_rd = sfr_rd && sfr_addr == sat_pkg::ADDR_CTRL;
   wire en = timer_irq_enable;
   always_ff @(posedge ref_clk) begin
      rd_q <= c_rd;
      cw_q <= c_wr;
      if (c_wr) begin
         last_wd <= sfr_wdata;
      end
      if (sys_rst) begin
         held <= 2'h0;
      end else if (c_wr) begin
         held <= held & sfr_wdata[7:6];
      end else if (rd_q && !cw_q) begin
         held <= held | sfr_rdata[7:6];
      end
   end
   // =========================================
   // assertions
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   rst_values_a: assert property ($fell(sys_rst) |->
      sfr_rdata == sat_pkg::BYTE_RESET && !timer_irq_req) else $error("state after reset");
   unmapped_read_a: assert property (sfr_rd && (sfr_addr < sat_pkg::ADDR_CTRL ||
      sfr_addr > sat_pkg::ADDR_COUNT_HI) |=> sfr_rdata == sat_pkg::READ_UNMAPPED)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   ctrl_readback_a: assert property (c_wr ##1 (c_rd && !sfr_wr) |=>
      sfr_rdata[5:0] == last_wd[5:0]) else $error("control readback differs");
   sticky_flags_a: assert property (c_rd && !c_wr |=>
      (sfr_rdata[7:6] & $past(held)) == $past(held)) else $error("flag dropped by hardware");
   irq_gate_a: assert property (timer_irq_req |-> $past(en) || $past(en, 2))
      else $error("request without enable");
   irq_off_a: assert property (!en [*2] |=> !timer_irq_req)
      else $error("request stays with enable low");
   upper_irq_a: assert property (c_rd && !c_wr && en ##1 sfr_rdata[7] && en
      |=> timer_irq_req) else $error("upper flag gives no request");
   lower_irq_a: assert property (c_rd && !c_wr && en ##1 sfr_rdata[6] && sfr_rdata[5]
      && en |=> timer_irq_req) else $error("lower flag gives no request");
endmodule
bind sat_timer sat_timer_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
   .upper_byte_system_clock_select(upper_byte_system_clock_select),
   .lower_byte_system_clock_select(lower_byte_system_clock_select), .ext_osc_div8(ext_osc_div8),
   .slow_osc_div8(slow_osc_div8), .slow_internal_oscillator(slow_internal_oscillator),
   .timer_irq_req(timer_irq_req));

// ==== verif/tb.sv ====
// self-checking bench for the split auto-reload timer
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] CT = sat_pkg::ADDR_CTRL;
   localparam logic [7:0] RL = sat_pkg::ADDR_RELOAD_LO;
   localparam logic [7:0] RH = sat_pkg::ADDR_RELOAD_HI;
   localparam logic [7:0] CL = sat_pkg::ADDR_COUNT_LO;
   localparam logic [7:0] CH = sat_pkg::ADDR_COUNT_HI;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic timer_irq_enable = 1'b0;
   logic upper_byte_system_clock_select = 1'b0;
   logic lower_byte_system_clock_select = 1'b0;
   logic ext_osc_div8 = 1'b0;
   logic slow_osc_div8 = 1'b0;
   logic slow_internal_oscillator = 1'b0;
   logic timer_irq_req;
   logic rd_q = 1'b0;
   logic [31:0] seed = 32'h2690AEF8;
   logic [15:0] notes[$];
   logic [15:0] nt;
   logic [7:0] alt_exp[4] = '{8'h0A, 8'h05, 8'h00, 8'h05};
   int error_cnt = 0;
   int compares = 0;
   always #5 ref_clk = ~ref_clk;
   sat_timer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .timer_irq_enable(timer_irq_enable), .upper_byte_system_clock_select(upper_byte_system_clock_select),
      .lower_byte_system_clock_select(lower_byte_system_clock_select), .ext_osc_div8(ext_osc_div8),
      .slow_osc_div8(slow_osc_div8), .slow_internal_oscillator(slow_internal_oscillator),
      .timer_irq_req(timer_irq_req));
   // =========================================
   // helpers: every bus op is entered and left at a falling edge
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      sfr_wr = w;
      sfr_rd = r;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
   endtask
   // expected value and compare mask are queued for the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      notes.push_back({m, e});
      op(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // =========================================
   // monitor: read data is settled by the falling edge after the read
   always @(posedge ref_clk) rd_q <= sfr_rd;
   always @(negedge ref_clk) begin
      if (rd_q) begin
         nt = notes.pop_front();
         chk("sfr_rdata", nt[7:0], sfr_rdata & nt[15:8]);
      end
   end
   initial begin
      // the scenarios need some 1,400 cycles; 6,000 can only mean a hang
      #60000;
      error_cnt++;
      close_out();
   end
   // =========================================
   // scenarios
   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      idle(1);
      for (int i = 0; i < 5; i++) begin
         rd(CT + 8'(i), sat_pkg::BYTE_RESET, 8'hFF);
      end
      // reserved source keeps counting stopped while control bits are random
      repeat (4) begin
         seed = nx(seed);
         rd({4'hA, seed[3:0]}, sat_pkg::READ_UNMAPPED, 8'hFF);
         wr(RL, seed[15:8]);
         rd(RL, seed[15:8], 8'hFF);
         wr(CT, {2'h0, seed[21:18], sat_pkg::ALT_RESERVED});
         rd(CT, {2'h0, seed[21:18], sat_pkg::ALT_RESERVED}, 8'hFF);
      end
      wr(CT, 8'h00);
      lower_byte_system_clock_select = 1'b1;
      timer_irq_enable = 1'b1;
      wr(CL, 8'hFF);
      wr(CH, 8'hFF);
      wr(RL, 8'h34);
      wr(RH, 8'h12);
      rd(CL, 8'hFF, 8'hFF);
      wr(CT, 8'h04);
      // flag-clearing write lands on the wrap edge
      wr(CT, 8'h20);
      rd(CL, 8'h34, 8'hFF);
      rd(CH, 8'h12, 8'hFF);
      rd(CT, 8'hE0, 8'hFF);
      rd(CT, 8'hE0, 8'hFF);
      chk("timer_irq_req", 8'h01, {7'h00, timer_irq_req});
      wr(CT, 8'h00);
      rd(CT, 8'h00, 8'hFF);
      chk("timer_irq_req", 8'h00, {7'h00, timer_irq_req});
      upper_byte_system_clock_select = 1'b1;
      wr(CH, 8'h55);
      wr(CT, 8'h08);
      idle(300);
      rd(CH, 8'h55, 8'hFF);
      rd(CT, 8'h48, 8'hFF);
      // lower flag alone raises no request until its own enable is set
      chk("timer_irq_req", 8'h00, {7'h00, timer_irq_req});
      wr(CT, 8'h68);
      idle(1);
      chk("timer_irq_req", 8'h01, {7'h00, timer_irq_req});
      wr(CH, 8'hFF);
      wr(RH, 8'hA0);
      wr(CT, 8'h0C);
      wr(CT, 8'h08);
      rd(CH, 8'hA0, 8'hFF);
      rd(CT, 8'h88, 8'hBF);
      upper_byte_system_clock_select = 1'b0;
      lower_byte_system_clock_select = 1'b0;
      // 120 counted edges per source: ten prescaler ticks, five pulses, or none for the reserved source
      // combined mode first, then split mode where both bytes take the same source
      foreach (alt_exp[i]) begin
         for (int m = 0; m < 2; m++) begin
            wr(CT, 8'h00);
            wr(CL, 8'h00);
            wr(CH, 8'h00);
            wr(CT, {4'h0, 1'(m), 1'h1, 2'(i)});
            repeat (5) begin
               {ext_osc_div8, slow_osc_div8} = 2'h3;
               idle(4);
               {ext_osc_div8, slow_osc_div8} = 2'h0;
               idle(4);
            end
            idle(79);
            wr(CT, 8'h00);
            rd(CL, alt_exp[i], 8'hFF);
            rd(CH, (m != 0) ? alt_exp[i] : 8'h00, 8'hFF);
         end
      end
      wr(CL, 8'hCD);
      wr(CH, 8'hAB);
      wr(CT, 8'h10);
      slow_internal_oscillator = 1'b1;
      idle(6);
      slow_internal_oscillator = 1'b0;
      idle(6);
      rd(RL, 8'hCD, 8'hFF);
      rd(RH, 8'hAB, 8'hFF);
      rd(CT, 8'h90, 8'hFF);
      chk("timer_irq_req", 8'h01, {7'h00, timer_irq_req});
      idle(2);
      close_out();
   end
endmodule
